/* hw/psg_pin_share.sv */
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Each pin carries a PWM output, a GPIO bit, or on two pins SPI1.
// [RULE2] Full variant: every shared pin selects its PWM function after reset.
// [RULE3] Reduced variant: reset selects no function; software must choose.
// [RULE4] GPIO direction is set per pin, independent of the others.
// [RULE5] Slave select pin, driven low by master, marks the transfer for us.
// [RULE6] Slave-out data pin is input as master, output as slave.
// [RULE7] As unselected slave the slave-out data pin floats.
// [RULE8] Slave data is placed half a clock before the master samples.
// [RULE9] Serial clock is driven as master, received as slave.
// [RULE10] Function select routes one source to pad, pad input to consumer.
module psg_pin_share
   import psg_pkg::*;
#(
   parameter bit FULL_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                    i_core_clk,
   input  wire logic                    i_reset,
   // Function select writes
   input  wire psg_sel_t                i_sel,
   // PWM generator
   input  wire logic [PSG_NUM_PINS-1:0] i_motor_pwm_out,
   // GPIO port
   input  wire logic [PSG_NUM_PINS-1:0] i_port_a_io_dir,
   input  wire logic [PSG_NUM_PINS-1:0] i_port_a_io_out,
   output logic [PSG_NUM_PINS-1:0]      o_port_a_io_in,
   // SPI channel 1 engine
   input  wire logic                    i_spi1_master,
   input  wire logic                    i_spi1_controller_in_data,
   output logic                         o_spi1_selected,
   output logic                         o_spi1_controller_in_data,
   // Pads
   input  wire logic [PSG_NUM_PINS-1:0] i_pad_in,
   output psg_pad_t                     o_pad,
   output psg_fn_t                      o_pin_fn_1,
   output psg_fn_t                      o_pin_fn_2,
   output psg_fn_t                      o_pin_fn_3
);

   // =========================================================
   // Function select storage
   localparam psg_fn_t RST_FN = FULL_VARIANT ? PSG_RST_FULL
                                             : PSG_RST_REDUCED;

   psg_fn_t sel_r [PSG_NUM_PINS];

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         for (int i = 0; i < PSG_NUM_PINS; i++) begin
            sel_r[i] <= RST_FN; // [RULE2] [RULE3]
         end
      end else if (i_sel.load && (i_sel.pin < 2'(PSG_NUM_PINS))) begin
         sel_r[i_sel.pin] <= i_sel.fn;
      end
   end

   assign o_pin_fn_1 = sel_r[PSG_PIN_1];
   assign o_pin_fn_2 = sel_r[PSG_PIN_SS];
   assign o_pin_fn_3 = sel_r[PSG_PIN_MISO];

   // =========================================================
   // Pad input synchroniser
   logic [PSG_NUM_PINS-1:0] pad_meta_r;
   logic [PSG_NUM_PINS-1:0] pad_sync_r;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         pad_meta_r <= '1;
         pad_sync_r <= '1;
      end else begin
         pad_meta_r <= i_pad_in;
         pad_sync_r <= pad_meta_r;
      end
   end

   // =========================================================
   // Consumers of pad inputs
   logic ss_fn;
   logic miso_fn;
   logic ss_active;

   assign ss_fn     = (sel_r[PSG_PIN_SS] == PSG_FN_SPI);
   assign miso_fn   = (sel_r[PSG_PIN_MISO] == PSG_FN_SPI);
   // Select pin is active low; unrouted means never selected
   assign ss_active = ss_fn
                   && (pad_sync_r[PSG_PIN_SS] != PSG_SS_IDLE); // [RULE5]

   logic [PSG_NUM_PINS-1:0] io_in_r;
   logic                    spi_sel_r;
   logic                    spi_din_r;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         io_in_r   <= '0;
         spi_sel_r <= 1'b0;
         spi_din_r <= 1'b0;
      end else begin
         for (int i = 0; i < PSG_NUM_PINS; i++) begin
            if (sel_r[i] == PSG_FN_GPIO) begin
               io_in_r[i] <= pad_sync_r[i]; // [RULE10]
            end
         end
         // Slave mode only: the engine then takes the clock as an input
         spi_sel_r <= ss_active && !i_spi1_master; // [RULE5] [RULE9]
         if (miso_fn && i_spi1_master) begin
            spi_din_r <= pad_sync_r[PSG_PIN_MISO]; // [RULE6]
         end
      end
   end

   assign o_port_a_io_in            = io_in_r;
   assign o_spi1_selected           = spi_sel_r;
   assign o_spi1_controller_in_data = spi_din_r;

   // =========================================================
   // Pad drive selection
   // Serial clock lives on a pin outside this group; the engine owns it.
   psg_pad_t pad_nxt;
   psg_pad_t pad_r;

   always_comb begin
      pad_nxt.out  = {PSG_NUM_PINS{PSG_PAD_IDLE}};
      pad_nxt.oe_n = {PSG_NUM_PINS{PSG_OE_FLOAT}};
      for (int i = 0; i < PSG_NUM_PINS; i++) begin
         case (sel_r[i])
            PSG_FN_PWM: begin
               pad_nxt.out[i]  = i_motor_pwm_out[i]; // [RULE1] [RULE10]
               pad_nxt.oe_n[i] = PSG_OE_DRIVE;
            end
            PSG_FN_GPIO: begin
               pad_nxt.out[i]  = i_port_a_io_out[i];
               pad_nxt.oe_n[i] = i_port_a_io_dir[i] ? PSG_OE_DRIVE
                                                    : PSG_OE_FLOAT; // [RULE4]
            end
            PSG_FN_SPI: begin
               // Only the data pin can drive; select is always an input
               if (i == PSG_PIN_MISO && !i_spi1_master && ss_active) begin
                  pad_nxt.out[i]  = i_spi1_controller_in_data; // [RULE8]
                  pad_nxt.oe_n[i] = PSG_OE_DRIVE; // [RULE6] [RULE7]
               end
            end
            default: begin
               pad_nxt.oe_n[i] = PSG_OE_FLOAT; // [RULE3]
            end
         endcase
      end
   end

   // Registered pads: one clock of latency, far below half an SPI period
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         pad_r.out  <= {PSG_NUM_PINS{PSG_PAD_IDLE}};
         pad_r.oe_n <= {PSG_NUM_PINS{PSG_OE_FLOAT}};
      end else begin
         pad_r <= pad_nxt;
      end
   end

   assign o_pad = pad_r;

   // =========================================================
   // Checks
   default clocking chk_cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_reset_release;
      $past(i_reset) ##0 !i_reset;
   endsequence

   sequence s_gpio_steady(int p);
      (sel_r[p] == PSG_FN_GPIO) [*3];
   endsequence

   sequence s_slave_chosen;
      miso_fn && !i_spi1_master && ss_active;
   endsequence

   chk_reset_full_pwm: assert property ( // [RULE2]
      s_reset_release ##0 FULL_VARIANT |->
         sel_r[0] == PSG_FN_PWM && sel_r[1] == PSG_FN_PWM &&
         sel_r[2] == PSG_FN_PWM)
      else $error("full variant pin not PWM after reset");

   chk_reset_reduced_none: assert property ( // [RULE3]
      s_reset_release ##0 !FULL_VARIANT |->
         sel_r[0] == PSG_FN_NONE && sel_r[1] == PSG_FN_NONE &&
         sel_r[2] == PSG_FN_NONE ##1 o_pad.oe_n == '1)
      else $error("reduced variant pin selected or driven after reset");

   chk_sel_load: assert property ( // [RULE10]
      i_sel.load && i_sel.pin == 2'd1 |=> sel_r[1] == $past(i_sel.fn))
      else $error("function select write lost");

   chk_pwm_route: assert property ( // [RULE1]
      sel_r[0] == PSG_FN_PWM |=>
         o_pad.out[0] == $past(i_motor_pwm_out[0]) &&
         o_pad.oe_n[0] == PSG_OE_DRIVE)
      else $error("PWM not routed to pad");

   chk_gpio_dir: assert property ( // [RULE4]
      sel_r[2] == PSG_FN_GPIO |=>
         o_pad.oe_n[2] == !$past(i_port_a_io_dir[2]))
      else $error("GPIO direction not honoured");

   chk_gpio_in_path: assert property ( // [RULE10]
      s_gpio_steady(0) ##1 sel_r[0] == PSG_FN_GPIO |->
         o_port_a_io_in[0] == $past(i_pad_in[0], 3))
      else $error("GPIO input not fed from pad");

   chk_ss_input_only: assert property ( // [RULE5]
      ss_fn |=> o_pad.oe_n[1] == PSG_OE_FLOAT)
      else $error("slave select pin driven");

   chk_ss_report: assert property ( // [RULE5]
      ss_fn && !i_spi1_master && !pad_sync_r[1] |=> o_spi1_selected)
      else $error("slave select not reported");

   chk_miso_master_in: assert property ( // [RULE6]
      miso_fn && i_spi1_master |=> o_pad.oe_n[2] == PSG_OE_FLOAT)
      else $error("data pin driven in master mode");

   chk_miso_unsel_float: assert property ( // [RULE7]
      miso_fn && !i_spi1_master && !ss_active |=>
         o_pad.oe_n[2] == PSG_OE_FLOAT)
      else $error("unselected slave drives data pin");

   chk_miso_slave_data: assert property ( // [RULE8]
      s_slave_chosen |=>
         o_pad.oe_n[2] == PSG_OE_DRIVE &&
         o_pad.out[2] == $past(i_spi1_controller_in_data))
      else $error("slave data not presented");

endmodule

/* hw/psg_pkg.sv */
package psg_pkg;

   // =========================================================
   // Pin indices
   localparam int PSG_NUM_PINS = 3;
   localparam int PSG_PIN_1    = 0;
   localparam int PSG_PIN_SS   = 1;
   localparam int PSG_PIN_MISO = 2;

   // =========================================================
   // Per-pin function choice
   typedef enum logic [1:0] {
      PSG_FN_NONE,
      PSG_FN_PWM,
      PSG_FN_SPI,
      PSG_FN_GPIO
   } psg_fn_t;

   // Reset choice per variant
   localparam psg_fn_t PSG_RST_FULL    = PSG_FN_PWM;
   localparam psg_fn_t PSG_RST_REDUCED = PSG_FN_NONE;

   // Pad drive levels
   localparam logic PSG_OE_DRIVE  = 1'b0;
   localparam logic PSG_OE_FLOAT  = 1'b1;
   localparam logic PSG_SS_IDLE   = 1'b1;
   localparam logic PSG_PAD_IDLE  = 1'b0;

   // =========================================================
   // Pad side carrier
   typedef struct packed {
      logic [PSG_NUM_PINS-1:0] out;
      logic [PSG_NUM_PINS-1:0] oe_n;
   } psg_pad_t;

   // Select write carrier
   typedef struct packed {
      logic       load;
      logic [1:0] pin;
      psg_fn_t    fn;
   } psg_sel_t;

endpackage

/* testbench/psg_far_end.sv */
`timescale 1ns/1ps

// =========================================================
// Remote SPI master and power stage resolving the shared pads
module psg_far_end
   import psg_pkg::*;
(
   // Device pads
   input  wire psg_pad_t                i_pad_seen,
   output logic [PSG_NUM_PINS-1:0]      o_pad_in,
   // Remote controls
   input  wire logic                    i_select_n,
   input  wire logic                    i_slave_en,
   input  wire logic                    i_slave_bit
);
   logic [PSG_NUM_PINS-1:0] far;

   // Pull-ups stand wherever nobody drives
   assign far[0] = 1'b1;
   assign far[1] = i_select_n;
   assign far[2] = i_slave_en ? i_slave_bit : 1'b1;
   assign o_pad_in = (i_pad_seen.out & ~i_pad_seen.oe_n)
                   | (far & i_pad_seen.oe_n);
endmodule

/* testbench/pwm_spi_gpio_pin_sharing_test.sv */
`timescale 1ns/1ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   err_count++; $display("unexpected at %0t: got %0h want %0h", \
   $time, g, e); end end

module pwm_spi_gpio_pin_sharing_test
   import psg_pkg::*;
;
   logic     clk = 0, rst = 1, mst = 0, eng = 0, sn = 1, sen = 0, sbit = 0;
   psg_sel_t sel = '0;
   logic [2:0] pwm = 3'h5, dir = 3'h0, iout = 3'h0, pin, ioin;
   logic     seld, cdat;
   psg_pad_t pad, rpad;
   psg_fn_t  f1, f2, f3, r1, r2, r3;
   int       err_count = 0, total_checks = 0, cyc = 0;

   psg_pin_share i_dut (.i_core_clk(clk), .i_reset(rst), .i_sel(sel),
      .i_motor_pwm_out(pwm), .i_port_a_io_dir(dir), .i_port_a_io_out(iout),
      .o_port_a_io_in(ioin), .i_spi1_master(mst),
      .i_spi1_controller_in_data(eng), .o_spi1_selected(seld),
      .o_spi1_controller_in_data(cdat), .i_pad_in(pin), .o_pad(pad),
      .o_pin_fn_1(f1), .o_pin_fn_2(f2), .o_pin_fn_3(f3));
   // Reduced variant shares every input
   psg_pin_share #(.FULL_VARIANT(1'b0)) i_dut_red (.i_core_clk(clk),
      .i_reset(rst), .i_sel(sel), .i_motor_pwm_out(pwm),
      .i_port_a_io_dir(dir), .i_port_a_io_out(iout), .o_port_a_io_in(),
      .i_spi1_master(mst), .i_spi1_controller_in_data(eng),
      .o_spi1_selected(), .o_spi1_controller_in_data(), .i_pad_in(pin),
      .o_pad(rpad), .o_pin_fn_1(r1), .o_pin_fn_2(r2), .o_pin_fn_3(r3));
   psg_far_end i_far (.i_pad_seen(pad), .o_pad_in(pin), .i_select_n(sn),
      .i_slave_en(sen), .i_slave_bit(sbit));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Ceiling well above the 46 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc >= 2000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Holding load across calls gives back-to-back writes
   task automatic write_sel(input logic [1:0] p, input psg_fn_t f);
      @(negedge clk) sel = '{load: 1'b1, pin: p, fn: f};
   endtask

   task automatic t_reset_state();
      `CHK({r1, r2, r3}, {3{PSG_FN_NONE}})
      `CHK(rpad.oe_n, 3'h7)
      `CHK({f1, f2, f3}, {3{PSG_FN_PWM}})
      `CHK(pad, {3'h5, 3'h0})
   endtask

   task automatic t_gpio();
      dir = 3'h5;
      iout = 3'h1;
      for (int i = 0; i < 3; i++) write_sel(2'(i), PSG_FN_GPIO);
      @(negedge clk) sel.load = 1'b0;
      wait_n(4);
      `CHK(pad, {3'h1, 3'h2})
      `CHK(ioin, 3'h3)
      sn = 1'b0;
      wait_n(4);
      `CHK(ioin, 3'h1)
   endtask

   task automatic t_spi_slave();
      sn = 1'b1;
      eng = 1'b1;
      write_sel(2'h1, PSG_FN_SPI);
      write_sel(2'h2, PSG_FN_SPI);
      @(negedge clk) sel.load = 1'b0;
      wait_n(4);
      `CHK(pad.oe_n, 3'h6)
      `CHK(seld, 1'b0)
      sn = 1'b0;
      wait_n(5);
      `CHK(seld, 1'b1)
      `CHK(pad.oe_n, 3'h2)
      `CHK(pad.out[2], 1'b1)
      eng = 1'b0;
      wait_n(2);
      `CHK(pad.out[2], 1'b0)
   endtask

   task automatic t_spi_master();
      mst = 1'b1;
      sen = 1'b1;
      sbit = 1'b1;
      wait_n(5);
      `CHK(pad.oe_n[2], 1'b1)
      `CHK(cdat, 1'b1)
      `CHK(seld, 1'b0)
      sbit = 1'b0;
      wait_n(4);
      `CHK(cdat, 1'b0)
   endtask

   task automatic t_refused();
      write_sel(2'h3, PSG_FN_GPIO);
      write_sel(2'h0, PSG_FN_SPI);
      @(negedge clk) sel.load = 1'b0;
      wait_n(3);
      `CHK({f1, f2, f3}, {3{PSG_FN_SPI}})
      `CHK(pad.oe_n[0], 1'b1)
   endtask

   initial begin
      wait_n(3);
      rst = 0;
      wait_n(2);
      t_reset_state();
      t_gpio();
      t_spi_slave();
      t_spi_master();
      t_refused();
      give_verdict();
   end
endmodule
